/* sdc_pkg.sv */
// shared types and constants of the dual converter spi access block
package sdc_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int          DAC_CODE_BITS  = 12;
  localparam int          ADC_RES_BITS   = 10;
  localparam logic [4:0]  DAC_FRAME_BITS = 5'h10;
  localparam logic [4:0]  ADC_CMD_BITS   = 5'h08;
  localparam logic [4:0]  BIT_CNT_MAX    = 5'h1F;
  localparam int          DAC_CH_POS     = 15;
  localparam logic [5:0]  ADC_PAD        = 6'h00;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [11:0] DAC_RESET      = 12'h000;
  localparam logic [9:0]  ADC_RESET      = 10'h000;
  localparam logic [9:0]  ADC_FULL_SCALE = 10'h3FF;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          SAMPLE_RATE_SPS = 72_000;
  localparam int          SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_SPS;
  localparam logic [10:0] SAMPLE_LAST     = 11'(SAMPLE_CYCLES - 1);
  localparam logic [10:0] PACE_RESET      = 11'h000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SDC_IDLE,
    SDC_DAC,
    SDC_ADC
  } sdc_phase_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic adc_select_n;
    logic dac_select_n;
  } sdc_spi_in_t;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } sdc_spi_out_t;

  typedef struct packed {
    logic        sclk_q;
    sdc_phase_t  phase;
    logic [4:0]  bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [11:0] dac0;
    logic [11:0] dac1;
    logic [9:0]  res0;
    logic [9:0]  res1;
    logic [10:0] pace;
    logic        conv_ch;
    logic        conv_stb;
  } sdc_state_t;

endpackage : sdc_pkg

/* sdc_access.sv */
// spi slave giving access to a two channel d/a and a two channel a/d
`timescale 1ns/10ps
// Overview of operation
// (RQ1) each converter answers only while its select low
// (RQ2) select left high means converter untouched
// (RQ3) shared bus: host drives clock, mosi; miso returns
// (RQ4) host selects alternate function zero on pins
// (RQ5) 12-bit code; narrow variants drop low bits
// (RQ6) 8-bit code sits in bits 4 to 11
// (RQ7) two channels, chosen within every access
// (RQ8) a/d result is 10-bit unsigned, 0 to 1023
// (RQ9) about 72k conversions per second overall
// (RQ10) host exchanges three bytes per a/d read
// (RQ11) d/a output linear in the written code
// (RQ12) host sets bus clock, clears flags first
// (RQ13) d/a write is two bytes, select low
// (RQ14) one select per transfer, high between
module sdc_access
  import sdc_pkg::*;
#(
  parameter int DAC_BITS = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // spi pins
  input  wire sdc_spi_in_t  spi_in,
  output      sdc_spi_out_t spi_out,
  // converter side
  input  wire logic [9:0]   analog_in_ch0,
  input  wire logic [9:0]   analog_in_ch1,
  output      logic [11:0]  analog_out_ch0,
  output      logic [11:0]  analog_out_ch1,
  output      logic         sample_strobe,
  output      logic         sample_ch
);

  // narrow variants ignore the low code bits
  localparam logic [11:0] LOW_MASK  = (12'h001 << (DAC_CODE_BITS - DAC_BITS))
                                      - 12'h001;
  localparam logic [11:0] CODE_MASK = ~LOW_MASK;

  sdc_state_t st;
  sdc_state_t next_st;
  logic       rise;
  logic       fall;

  // ****************************************
  // bus clock edges
  // ****************************************
  // sclk is slow against clk, so edges are found by sampling
  assign rise = spi_in.sclk & ~st.sclk_q;
  assign fall = ~spi_in.sclk & st.sclk_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st          = st;
    next_st.sclk_q   = spi_in.sclk;
    next_st.conv_stb = 1'b0;

    // conversion pacing, channels alternate
    if (st.pace == SAMPLE_LAST) begin // see RQ9
      next_st.pace     = PACE_RESET;
      next_st.conv_stb = 1'b1;
      next_st.conv_ch  = ~st.conv_ch;
      if (st.conv_ch) begin // see RQ7
        next_st.res1 = analog_in_ch1; // see RQ8
      end else begin
        next_st.res0 = analog_in_ch0;
      end
    end else begin
      next_st.pace = st.pace + 11'h001;
    end

    case (st.phase)
      SDC_IDLE: begin
        next_st.bit_cnt = 5'h00;
        // both low at once is a host fault: nobody answers
        if (!spi_in.adc_select_n && spi_in.dac_select_n) begin // see RQ1
          next_st.phase = SDC_ADC;
        end else if (!spi_in.dac_select_n && spi_in.adc_select_n) begin
          next_st.phase = SDC_DAC; // see RQ2
        end
      end
      SDC_DAC: begin
        if (spi_in.dac_select_n) begin
          next_st.phase = SDC_IDLE;
          // only a whole 16 bit frame updates an output
          if (st.bit_cnt == DAC_FRAME_BITS) begin // see RQ13
            if (st.rx[DAC_CH_POS]) begin // see RQ7
              next_st.dac1 = st.rx[11:0] & CODE_MASK; // see RQ5
            end else begin
              next_st.dac0 = st.rx[11:0] & CODE_MASK; // see RQ11
            end
          end
        end else if (rise) begin
          next_st.rx = {st.rx[14:0], spi_in.mosi}; // see RQ3
          if (st.bit_cnt != BIT_CNT_MAX) begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
          end
        end
      end
      SDC_ADC: begin
        if (spi_in.adc_select_n) begin
          next_st.phase = SDC_IDLE;
        end else if (rise) begin
          next_st.rx = {st.rx[14:0], spi_in.mosi};
          if (st.bit_cnt != BIT_CNT_MAX) begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
          end
          // last bit of the command byte picks the channel
          if (st.bit_cnt == ADC_CMD_BITS - 5'h01) begin // see RQ7
            next_st.tx = spi_in.mosi ? {ADC_PAD, st.res1}
                                     : {ADC_PAD, st.res0}; // see RQ8
          end
        end else if (fall && st.bit_cnt > ADC_CMD_BITS) begin
          next_st.tx = {st.tx[14:0], 1'b0}; // see RQ3
        end
      end
      default: begin
        next_st.phase = SDC_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{sclk_q:   1'b0,
              phase:    SDC_IDLE,
              bit_cnt:  5'h00,
              rx:       16'h0000,
              tx:       16'h0000,
              dac0:     DAC_RESET,
              dac1:     DAC_RESET,
              res0:     ADC_RESET,
              res1:     ADC_RESET,
              pace:     PACE_RESET,
              conv_ch:  1'b0,
              conv_stb: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign spi_out.miso    = st.tx[15];
  // miso released whenever the a/d is not selected
  assign spi_out.miso_oe = (st.phase == SDC_ADC) &
                           ~spi_in.adc_select_n; // see RQ1
  assign analog_out_ch0  = st.dac0;
  assign analog_out_ch1  = st.dac1;
  assign sample_strobe   = st.conv_stb;
  assign sample_ch       = ~st.conv_ch;

  // ****************************************
  // checks
  // ****************************************
  logic [10:0] gap;
  logic        gap_ok;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap    <= 11'h000;
      gap_ok <= 1'b0;
    end else if (st.conv_stb) begin
      gap    <= 11'h001;
      gap_ok <= 1'b1;
    end else begin
      gap    <= gap + 11'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_dac_end_ch1;
    st.phase == SDC_DAC && spi_in.dac_select_n &&
    st.bit_cnt == DAC_FRAME_BITS && st.rx[DAC_CH_POS];
  endsequence

  sequence s_dac_end_ch0;
    st.phase == SDC_DAC && spi_in.dac_select_n &&
    st.bit_cnt == DAC_FRAME_BITS && !st.rx[DAC_CH_POS];
  endsequence

  chk_oe_own_select: assert property ( // see RQ1
    spi_out.miso_oe |-> !spi_in.adc_select_n &&
      $past(!spi_in.adc_select_n))
    else $error("miso driven without a/d select");

  chk_dac_needs_frame: assert property ( // see RQ1
    (analog_out_ch0 != $past(analog_out_ch0)) |->
      $past(st.phase) == SDC_DAC && $past(st.bit_cnt) == DAC_FRAME_BITS)
    else $error("d/a output changed outside a frame");

  chk_idle_when_high: assert property ( // see RQ2
    st.phase == SDC_IDLE && spi_in.adc_select_n && spi_in.dac_select_n
      |=> st.phase == SDC_IDLE)
    else $error("left idle with both selects high");

  chk_miso_shift: assert property ( // see RQ3
    st.phase == SDC_ADC && !spi_in.adc_select_n && fall &&
      st.bit_cnt > ADC_CMD_BITS |=> spi_out.miso == $past(st.tx[14]))
    else $error("miso did not advance on falling edge");

  chk_dac_low_bits: assert property ( // see RQ5
    (analog_out_ch0 & LOW_MASK) == 12'h000 &&
      (analog_out_ch1 & LOW_MASK) == 12'h000)
    else $error("ignored d/a bits are set");

  chk_dac_ch_one: assert property ( // see RQ7
    s_dac_end_ch1 |=> analog_out_ch1 == ($past(st.rx[11:0]) & CODE_MASK)
      && $stable(analog_out_ch0))
    else $error("channel one write went wrong");

  chk_dac_linear: assert property ( // see RQ11
    s_dac_end_ch0 |=> analog_out_ch0 == ($past(st.rx[11:0]) & CODE_MASK)
      && $stable(analog_out_ch1))
    else $error("channel zero output not the written code");

  chk_result_pad: assert property ( // see RQ8
    st.phase == SDC_ADC && st.bit_cnt == ADC_CMD_BITS && $changed(st.tx)
      |-> st.tx[15:10] == ADC_PAD)
    else $error("a/d result wider than ten bits");

  chk_sample_rate: assert property ( // see RQ9
    st.conv_stb && gap_ok |-> gap == 11'(SAMPLE_CYCLES))
    else $error("conversion spacing wrong");

  chk_sample_alt: assert property ( // see RQ7
    $rose(st.conv_stb) |-> sample_ch != $past(sample_ch) ##1
      (!st.conv_stb)[*8])
    else $error("conversions do not alternate channels");

endmodule : sdc_access

/* sdc_host_model.sv */
// host spi master model for the converter access block
`timescale 1ns/10ps
module sdc_host_model
  import sdc_pkg::*;
(
  // clock
  input  wire logic         clk,
  // spi pins
  output      sdc_spi_in_t  spi_in,
  input  wire sdc_spi_out_t spi_out
);
  // ***********
  // transfers
  // ***********
  localparam int HALF = 2;

  initial spi_in = '{1'b0, 1'b0, 1'b1, 1'b1};

  // sel_n is {adc, dac}; mode 0, msb first
  task automatic xfer(input logic [1:0] sel_n, input logic [23:0] d,
                      input int n, output logic [23:0] rx,
                      output int noe);
    rx = '0;
    noe = 0;
    spi_in.adc_select_n = sel_n[1];
    spi_in.dac_select_n = sel_n[0];
    repeat (HALF) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      spi_in.mosi = d[i];
      repeat (HALF) @(negedge clk);
      rx = {rx[22:0], spi_out.miso};
      if (spi_out.miso_oe === 1'b1) noe++;
      spi_in.sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      spi_in.sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    // released data line must not keep its last level
    spi_in = '{1'b0, ~spi_in.mosi, 1'b1, 1'b1};
    repeat (3) @(negedge clk);
  endtask : xfer
endmodule : sdc_host_model

/* tb_top.sv */
// self-checking bench of the converter access block
`timescale 1ns/10ps
module tb_top
  import sdc_pkg::*;
;
  // ***********
  // parts
  // ***********
  localparam int DB = 8;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  sdc_spi_in_t  spi_in;
  sdc_spi_out_t spi_out;
  logic [9:0]   ain [2];
  logic [11:0]  aout [2];
  logic         strobe;
  logic         sch;
  int           n_errors = 0;
  int           n_compared = 0;
  logic [15:0]  seed = 16'h003D;
  int           gap = 0;
  logic         last_ch = 1'b1;

  always #5 clk = ~clk;

  sdc_access #(.DAC_BITS(DB)) sdc_access_i (
    .clk(clk), .nrst(nrst), .spi_in(spi_in), .spi_out(spi_out),
    .analog_in_ch0(ain[0]), .analog_in_ch1(ain[1]),
    .analog_out_ch0(aout[0]), .analog_out_ch1(aout[1]),
    .sample_strobe(strobe), .sample_ch(sch));

  sdc_host_model sdc_host_model_i (
    .clk(clk), .spi_in(spi_in), .spi_out(spi_out));

  // ***********
  // helpers
  // ***********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [11:0] dac_exp(input logic [11:0] c);
    return c & (12'hFFF << (12 - DB));
  endfunction : dac_exp

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // conversion pacing and channel alternation
  // looked at mid-cycle, where the registered strobe has settled
  always @(negedge clk) begin
    if (strobe === 1'b1) begin
      if (gap > 0) check(16'(gap), 16'(SAMPLE_CYCLES));
      check(16'(sch), {15'h0000, ~last_ch});
      last_ch = sch;
      gap = 1;
    end else if (gap > 0) gap++;
  end

  // ***********
  // scenarios
  // ***********
  initial begin
    logic [23:0] rx;
    int          noe;
    logic [11:0] code;
    logic [11:0] want [2];
    ain[0] = 10'h000;
    ain[1] = 10'h3FF;
    want[0] = 12'h000;
    want[1] = 12'h000;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check(16'(spi_out), 16'h0000);
    // first two codes: full scale and a dropped low bit
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      code = (i < 2) ? (12'hFF0 | 12'(i)) : seed[11:0];
      sdc_host_model_i.xfer(2'b10, {8'h00, i[0], 3'b000, code}, 16,
                            rx, noe);
      want[i % 2] = dac_exp(code);
      check(16'(aout[0]), 16'(want[0]));
      check(16'(aout[1]), 16'(want[1]));
      check(16'(noe), 16'h0000);
    end
    // both low, a/d only, short d/a, none: d/a must hold
    for (int k = 0; k < 4; k++) begin
      sdc_host_model_i.xfer(2'(k), {8'h00, 16'h85A5},
                            (k == 2) ? 15 : 16, rx, noe);
      check(16'(aout[1]), 16'(want[1]));
      check(16'(aout[0]), 16'(want[0]));
      check(16'(noe), (k == 1) ? 16'h0010 : 16'h0000);
    end
    for (int j = 0; j < 4; j++) begin
      if (j > 0) begin
        seed = lfsr(seed);
        ain[0] = seed[9:0];
        seed = lfsr(seed);
        ain[1] = seed[9:0];
      end
      repeat (2 * SAMPLE_CYCLES + 4) @(negedge clk);
      for (int c = 0; c < 2; c++) begin
        sdc_host_model_i.xfer(2'b01, {7'h00, c[0], 16'h0000}, 24,
                              rx, noe);
        check(rx[15:0], {6'h00, ain[c]});
        check(16'(noe), 16'h0018);
      end
    end
    tally_and_finish();
  end

  // whole run needs well under 20k cycles
  initial begin
    #300_000;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
